// ### core/baud_gen.sv
`timescale 1ns/10ps
module baud_gen (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [7:0] prescale,
  // edge strobes
  output logic            lead_p,
  output logic            trail_p
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] last_cnt;
  logic [8:0] period;
  logic [7:0] half;

  // prescale 0 gives the same two-cycle period as prescale 1
  assign last_cnt = (prescale == 8'h00) ? 8'h01 : prescale;
  assign period   = {1'b0, last_cnt} + 9'h001;
  assign half     = period[8:1];
  assign cnt_nxt  = !run ? 8'h00 : (cnt_r == last_cnt) ? 8'h00 : cnt_r + 8'h01;
  assign lead_p   = run && (cnt_r == 8'h00);
  assign trail_p  = run && (cnt_r == half);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ### core/serial_port.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module serial_port (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial clock pin
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  // controller-out data pin
  input  wire logic        controller_out_data_pin_i,
  output logic             controller_out_data_pin_o,
  output logic             controller_out_data_pin_oe,
  // controller-in data pin
  input  wire logic        controller_in_data_pin_i,
  output logic             controller_in_data_pin_o,
  output logic             controller_in_data_pin_oe,
  // select pin, active low
  input  wire logic        select_n_pin_i,
  output logic             select_n_pin_o,
  output logic             select_n_pin_oe
);
  // ************************
  // registers and storage
  // ************************
  logic [2:0]   ctrl_r;
  logic [15:0]  grp_r;
  logic [15:0]  select_delay_register_r;
  logic [17:0]  word_format_register_r [serial_port_pkg::NUM_FMT];
  logic [7:0]   bidx_r;
  logic [11:0]  gpio_r;
  logic [15:0]  rxbuf_r;
  logic         rx_full_r;
  logic         ovr_r;
  logic [15:0]  tx_m  [serial_port_pkg::NUM_ENTRIES];
  logic [15:0]  ctl_m [serial_port_pkg::NUM_ENTRIES];
  logic [15:0]  rx_m  [serial_port_pkg::NUM_ENTRIES];
  logic [15:0]  st_m  [serial_port_pkg::NUM_ENTRIES];
  serial_port_pkg::state_t state_r;
  serial_port_pkg::state_t state_nxt;
  logic [7:0]   cur_r;
  logic [7:0]   cur_nxt;
  logic [7:0]   dcnt_r;
  logic [7:0]   dcnt_nxt;
  logic         sclk_lvl_r;
  logic [3:0]   s1_r;
  logic [3:0]   s2_r;
  logic [3:0]   s3_r;
  logic         pready_r;
  logic         pslverr_r;
  logic [31:0]  prdata_r;
  logic [3:0]   pin_o_r;
  logic [3:0]   pin_oe_r;

  // ************************
  // decode
  // ************************
  logic        setup_ph;
  logic        wr_done;
  logic        rd_done;
  logic [31:0] rdata;
  logic        hit;
  logic        fmt_hit;
  logic [1:0]  fmt_sel_w;
  logic        en;
  logic        ctlr;
  logic [1:0]  afmt_sel;
  logic [17:0] afmt;
  logic [4:0]  alen;
  logic        apol;
  logic        apha;
  logic [7:0]  grp_start;
  logic [7:0]  grp_end;
  logic        sel_low;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        shifting;
  logic        run;
  logic        lead_p;
  logic        trail_p;
  logic        bg_lead;
  logic        bg_trail;
  logic        eng_in;
  logic        eng_out;
  logic        eng_done;
  logic [15:0] eng_rx;
  logic        word_done;
  logic        go_take;
  logic        sclk_nxt;
  logic        sel_n_nxt;
  logic [3:0]  role_o;
  logic [3:0]  role_oe;

  assign setup_ph  = psel && !penable;
  assign wr_done   = psel && penable && pready_r && pwrite;
  assign rd_done   = psel && penable && pready_r && !pwrite;
  assign fmt_hit   = (paddr[7:4] == serial_port_pkg::OFS_FMT0[7:4]) && (paddr[1:0] == 2'b00);
  assign fmt_sel_w = paddr[3:2];
  assign en        = ctrl_r[serial_port_pkg::CTRL_EN];
  assign ctlr      = ctrl_r[serial_port_pkg::CTRL_CTLR];
  assign grp_start = grp_r[7:0];
  assign grp_end   = grp_r[15:8];
  assign afmt_sel  = ctl_m[cur_r][1:0];
  assign afmt      = word_format_register_r[afmt_sel];
  assign alen      = serial_port_pkg::word_len(afmt[4:0]);
  assign apol      = afmt[serial_port_pkg::FMT_POL];
  assign apha      = afmt[serial_port_pkg::FMT_PHA];
  assign sel_low   = !s2_r[serial_port_pkg::PIN_SEL];
  assign sclk_rise = s2_r[serial_port_pkg::PIN_SCLK] && !s3_r[serial_port_pkg::PIN_SCLK];
  assign sclk_fall = !s2_r[serial_port_pkg::PIN_SCLK] && s3_r[serial_port_pkg::PIN_SCLK];
  assign shifting  = (state_r == serial_port_pkg::ST_SHIFT);
  assign run       = shifting && ctlr;
  // target edges come from the far side's clock, seen after the synchroniser
  assign lead_p    = shifting && (ctlr ? bg_lead : (apol ? sclk_fall : sclk_rise));
  assign trail_p   = shifting && (ctlr ? bg_trail : (apol ? sclk_rise : sclk_fall));
  assign eng_in    = ctlr ? s2_r[serial_port_pkg::PIN_CIN] : s2_r[serial_port_pkg::PIN_COUT];
  assign word_done = shifting && eng_done;
  assign go_take   = (state_r == serial_port_pkg::ST_IDLE) && en && ctlr
                     && ctrl_r[serial_port_pkg::CTRL_GO];

  // ************************
  // register read
  // ************************
  always_comb begin
    hit   = 1'b1;
    rdata = serial_port_pkg::RST_WORD;
    if (paddr == serial_port_pkg::OFS_CTRL) begin
      rdata = {29'h0, ctrl_r};
    end else if (paddr == serial_port_pkg::OFS_GROUP) begin
      rdata = {16'h0, grp_r};
    end else if (paddr == serial_port_pkg::OFS_DELAY) begin
      rdata = {16'h0, select_delay_register_r};
    end else if (fmt_hit) begin
      rdata = {14'h0, word_format_register_r[fmt_sel_w]};
    end else if (paddr == serial_port_pkg::OFS_STATUS) begin
      rdata = {16'h0, cur_r, 5'h0, ovr_r, rx_full_r, !state_r[0]};
    end else if (paddr == serial_port_pkg::OFS_RXBUF) begin
      rdata = {16'h0, rxbuf_r};
    end else if (paddr == serial_port_pkg::OFS_BIDX) begin
      rdata = {24'h0, bidx_r};
    end else if (paddr == serial_port_pkg::OFS_BTX) begin
      rdata = {16'h0, tx_m[bidx_r]};
    end else if (paddr == serial_port_pkg::OFS_BCTL) begin
      rdata = {16'h0, ctl_m[bidx_r]};
    end else if (paddr == serial_port_pkg::OFS_BRX) begin
      rdata = {16'h0, rx_m[bidx_r]};
    end else if (paddr == serial_port_pkg::OFS_BSTAT) begin
      rdata = {16'h0, st_m[bidx_r]};
    end else if (paddr == serial_port_pkg::OFS_GPIO) begin
      rdata = {12'h0, s2_r, 4'h0, gpio_r};
    end else begin
      hit = 1'b0;
    end
  end

  // ************************
  // apb answer
  // ************************
  // one access cycle always; read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= serial_port_pkg::RST_WORD;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !hit;
      prdata_r  <= setup_ph ? rdata : serial_port_pkg::RST_WORD;
    end
  end

  // ************************
  // software registers
  // ************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r                  <= 3'h0;
      grp_r                   <= 16'h0000;
      select_delay_register_r <= 16'h0000;
      bidx_r                  <= 8'h00;
      gpio_r                  <= 12'h000;
      for (int i = 0; i < serial_port_pkg::NUM_FMT; i++) begin
        word_format_register_r[i] <= 18'h00000;
      end
    end else begin
      if (go_take) begin
        ctrl_r[serial_port_pkg::CTRL_GO] <= 1'b0;
      end
      if (wr_done && hit) begin
        if (paddr == serial_port_pkg::OFS_CTRL) begin
          ctrl_r <= pwdata[2:0];
        end else if (paddr == serial_port_pkg::OFS_GROUP) begin
          grp_r <= pwdata[15:0];
        end else if (paddr == serial_port_pkg::OFS_DELAY) begin
          select_delay_register_r <= pwdata[15:0];
        end else if (fmt_hit) begin
          word_format_register_r[fmt_sel_w] <= pwdata[17:0];
        end else if (paddr == serial_port_pkg::OFS_BIDX) begin
          bidx_r <= pwdata[7:0];
        end else if (paddr == serial_port_pkg::OFS_GPIO) begin
          gpio_r <= pwdata[11:0];
        end
      end
    end
  end

  // ************************
  // buffer memory
  // ************************
  // software owns transmit and control words, the port owns receive and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < serial_port_pkg::NUM_ENTRIES; i++) begin
        tx_m[i]  <= 16'h0000;
        ctl_m[i] <= 16'h0000;
        rx_m[i]  <= 16'h0000;
        st_m[i]  <= 16'h0000;
      end
    end else begin
      if (wr_done && paddr == serial_port_pkg::OFS_BTX) begin
        tx_m[bidx_r] <= pwdata[15:0];
      end
      if (wr_done && paddr == serial_port_pkg::OFS_BCTL) begin
        ctl_m[bidx_r] <= pwdata[15:0];
      end
      if (wr_done && paddr == serial_port_pkg::OFS_BSTAT) begin
        st_m[bidx_r] <= 16'h0000;
      end
      // a completion after the clear above wins
      if (word_done) begin
        rx_m[cur_r]                          <= eng_rx;
        st_m[cur_r][serial_port_pkg::ES_DONE] <= 1'b1;
        st_m[cur_r][serial_port_pkg::ES_OVR]  <= rx_full_r;
      end
    end
  end

  // ************************
  // receive buffer
  // ************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_r   <= 16'h0000;
      rx_full_r <= 1'b0;
      ovr_r     <= 1'b0;
    end else begin
      if (word_done) begin
        rxbuf_r   <= eng_rx;
        rx_full_r <= 1'b1;
      end else if (rd_done && paddr == serial_port_pkg::OFS_RXBUF) begin
        rx_full_r <= 1'b0;
      end
      if (word_done && rx_full_r) begin
        ovr_r <= 1'b1;
      end else if (wr_done && paddr == serial_port_pkg::OFS_STATUS
                   && pwdata[serial_port_pkg::SR_OVR]) begin
        ovr_r <= 1'b0;
      end
    end
  end

  // ************************
  // transfer sequencer
  // ************************
  always_comb begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    dcnt_nxt  = dcnt_r;
    case (state_r)
      serial_port_pkg::ST_IDLE: begin
        if (go_take) begin
          cur_nxt   = grp_start;
          state_nxt = serial_port_pkg::ST_LOAD;
        end else if (en && !ctlr && sel_low) begin
          state_nxt = serial_port_pkg::ST_LOAD;
        end
      end
      serial_port_pkg::ST_LOAD: begin
        dcnt_nxt  = select_delay_register_r[7:0];
        state_nxt = ctlr ? serial_port_pkg::ST_SETUP : serial_port_pkg::ST_SHIFT;
      end
      serial_port_pkg::ST_SETUP: begin
        if (dcnt_r == 8'h00) begin
          state_nxt = serial_port_pkg::ST_SHIFT;
        end else begin
          dcnt_nxt = dcnt_r - 8'h01;
        end
      end
      serial_port_pkg::ST_SHIFT: begin
        if (eng_done) begin
          dcnt_nxt  = select_delay_register_r[15:8];
          state_nxt = ctlr ? serial_port_pkg::ST_HOLD : serial_port_pkg::ST_NEXT;
        end else if (!ctlr && !sel_low) begin
          state_nxt = serial_port_pkg::ST_IDLE;   // far side dropped select mid-word
        end
      end
      serial_port_pkg::ST_HOLD: begin
        if (dcnt_r == 8'h00) begin
          state_nxt = serial_port_pkg::ST_NEXT;
        end else begin
          dcnt_nxt = dcnt_r - 8'h01;
        end
      end
      serial_port_pkg::ST_NEXT: begin
        cur_nxt   = (cur_r == grp_end) ? grp_start : cur_r + 8'h01;
        state_nxt = (ctlr && cur_r != grp_end) ? serial_port_pkg::ST_LOAD
                                               : serial_port_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = serial_port_pkg::ST_IDLE;
      end
    endcase
    if (!en) begin
      state_nxt = serial_port_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= serial_port_pkg::ST_IDLE;
      cur_r   <= 8'h00;
      dcnt_r  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      dcnt_r  <= dcnt_nxt;
    end
  end

  // ************************
  // serial datapath
  // ************************
  baud_gen u_baud (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run),
    .prescale (afmt[serial_port_pkg::FMT_PS_LSB +: 8]),
    .lead_p   (bg_lead),
    .trail_p  (bg_trail)
  );

  shift_engine u_shift (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (state_r == serial_port_pkg::ST_LOAD),
    .tx_word  (tx_m[cur_r]),
    .len      (alen),
    .cpha     (apha),
    .lead_p   (lead_p),
    .trail_p  (trail_p),
    .in_bit   (eng_in),
    .out_bit  (eng_out),
    .rx_word  (eng_rx),
    .done     (eng_done)
  );

  // ************************
  // pins
  // ************************
  // idle level follows polarity; leading edge leaves it, trailing edge returns
  assign sclk_nxt  = !run ? apol : lead_p ? !apol : trail_p ? apol : sclk_lvl_r;
  assign sel_n_nxt = !(ctlr && (state_nxt == serial_port_pkg::ST_SETUP
                     || state_nxt == serial_port_pkg::ST_SHIFT
                     || state_nxt == serial_port_pkg::ST_HOLD));
  assign role_o    = {sel_n_nxt, eng_out, eng_out, sclk_nxt};
  assign role_oe   = {en && ctlr, en && !ctlr && sel_low, en && ctlr, en && ctlr};

  // input synchroniser; stage two feeds logic, stage three only the clock edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r       <= 4'hf;
      s2_r       <= 4'hf;
      s3_r       <= 4'hf;
      sclk_lvl_r <= 1'b0;
    end else begin
      s1_r       <= {select_n_pin_i, controller_in_data_pin_i,
                     controller_out_data_pin_i, serial_clock_pin_i};
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      sclk_lvl_r <= sclk_nxt;
    end
  end

  // each of the four pins becomes general i/o under gpio control when its gpio_r enable bit is set
  for (genvar p = 0; p < serial_port_pkg::NUM_PINS; p++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_o_r[p]  <= 1'b1;
        pin_oe_r[p] <= 1'b0;
      end else if (gpio_r[p]) begin
        pin_o_r[p]  <= gpio_r[8 + p];
        pin_oe_r[p] <= gpio_r[4 + p];
      end else begin
        pin_o_r[p]  <= role_o[p];
        pin_oe_r[p] <= role_oe[p];
      end
    end
  end

  assign prdata                     = prdata_r;
  assign pready                     = pready_r;
  assign pslverr                    = pslverr_r;
  assign serial_clock_pin_o         = pin_o_r[serial_port_pkg::PIN_SCLK];
  assign serial_clock_pin_oe        = pin_oe_r[serial_port_pkg::PIN_SCLK];
  assign controller_out_data_pin_o  = pin_o_r[serial_port_pkg::PIN_COUT];
  assign controller_out_data_pin_oe = pin_oe_r[serial_port_pkg::PIN_COUT];
  assign controller_in_data_pin_o   = pin_o_r[serial_port_pkg::PIN_CIN];
  assign controller_in_data_pin_oe  = pin_oe_r[serial_port_pkg::PIN_CIN];
  assign select_n_pin_o             = pin_o_r[serial_port_pkg::PIN_SEL];
  assign select_n_pin_oe            = pin_oe_r[serial_port_pkg::PIN_SEL];
endmodule

// ### core/serial_port_pkg.sv
package serial_port_pkg;
  // ************************
  // register offsets
  // ************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GROUP  = 8'h04;
  localparam logic [7:0] OFS_DELAY  = 8'h08;
  localparam logic [7:0] OFS_FMT0   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RXBUF  = 8'h24;
  localparam logic [7:0] OFS_BIDX   = 8'h28;
  localparam logic [7:0] OFS_BTX    = 8'h2c;
  localparam logic [7:0] OFS_BCTL   = 8'h30;
  localparam logic [7:0] OFS_BRX    = 8'h34;
  localparam logic [7:0] OFS_BSTAT  = 8'h38;
  localparam logic [7:0] OFS_GPIO   = 8'h3c;
  // ************************
  // fields and sizes
  // ************************
  localparam int CTRL_EN      = 0;
  localparam int CTRL_CTLR    = 1;
  localparam int CTRL_GO      = 2;
  localparam int FMT_PS_LSB   = 8;
  localparam int FMT_PHA      = 16;
  localparam int FMT_POL      = 17;
  localparam int SR_BUSY      = 0;
  localparam int SR_FULL      = 1;
  localparam int SR_OVR       = 2;
  localparam int ES_DONE      = 0;
  localparam int ES_OVR       = 1;
  localparam int NUM_ENTRIES  = 256;
  localparam int NUM_FMT      = 4;
  localparam int NUM_PINS     = 4;
  localparam int PIN_SCLK     = 0;
  localparam int PIN_COUT     = 1;
  localparam int PIN_CIN      = 2;
  localparam int PIN_SEL      = 3;
  localparam logic [4:0] MIN_LEN = 5'h02;
  localparam logic [4:0] MAX_LEN = 5'h10;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_LOAD  = 6'b000010,
    ST_SETUP = 6'b000100,
    ST_SHIFT = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_NEXT  = 6'b100000
  } state_t;

  // out-of-range lengths are pulled into 2..16
  function automatic logic [4:0] word_len(input logic [4:0] f);
    if (f < MIN_LEN) begin
      return MIN_LEN;
    end else if (f > MAX_LEN) begin
      return MAX_LEN;
    end
    return f;
  endfunction
endpackage

// ### core/shift_engine.sv
`timescale 1ns/10ps
module shift_engine (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // word setup
  input  wire logic        start,
  input  wire logic [15:0] tx_word,
  input  wire logic [4:0]  len,
  input  wire logic        cpha,
  // serial edges and data
  input  wire logic        lead_p,
  input  wire logic        trail_p,
  input  wire logic        in_bit,
  output logic             out_bit,
  // result
  output logic [15:0]      rx_word,
  output logic             done
);
  logic [15:0] sh_r;
  logic [15:0] rx_r;
  logic [4:0]  cnt_r;
  logic        sample_ev;
  logic        shift_ev;
  logic [15:0] rx_nxt;
  logic [4:0]  cnt_inc;
  logic [4:0]  cnt_after;
  logic [4:0]  pad;
  localparam logic [4:0] MAX_LEN_C = serial_port_pkg::MAX_LEN;

  // phase 0 samples on the leading edge, phase 1 on the trailing one
  assign sample_ev = cpha ? trail_p : lead_p;
  assign shift_ev  = cpha ? (lead_p && cnt_r != 5'h00) : trail_p;
  assign rx_nxt    = {rx_r[14:0], in_bit};
  assign cnt_inc   = cnt_r + 5'h01;
  assign cnt_after = sample_ev ? cnt_inc : cnt_r;
  assign done      = trail_p && (cnt_after == len);
  assign rx_word   = sample_ev ? rx_nxt : rx_r;
  assign pad       = MAX_LEN_C - len;
  assign out_bit   = sh_r[15];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r  <= 16'h0000;
      rx_r  <= 16'h0000;
      cnt_r <= 5'h00;
    end else if (start) begin
      sh_r  <= tx_word << pad;   // msb first, word left-aligned
      rx_r  <= 16'h0000;
      cnt_r <= 5'h00;
    end else begin
      if (sample_ev) begin
        rx_r  <= rx_nxt;
        cnt_r <= cnt_inc;
      end
      if (shift_ev) begin
        sh_r <= {sh_r[14:0], 1'b0};
      end
    end
  end
endmodule

// ### test/multibuffered_serial_port_tb_top.sv
`timescale 1ns/10ps
// ************************
// bench top
// ************************
module multibuffered_serial_port_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, er, pha;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, m;
  logic [15:0] dtx, ptx, prx;
  logic [4:0]  len;
  logic [31:0] q[$];
  int          fails, total_checks, seed, t;
  wire [31:0]  prdata;
  wire         pready, pslverr, sk_o, sk_oe, co_o, co_oe, ci_o, ci_oe, sn_o, sn_oe, pcin;
  wire         sk_w = sk_oe ? sk_o : 1'b0;
  wire         co_w = co_oe ? co_o : 1'b0;
  wire         ci_w = ci_oe ? ci_o : pcin;
  wire         sn_w = sn_oe ? sn_o : 1'b1;
  logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24};
  logic [7:0]  pss[4] = '{8'h07, 8'h0f, 8'hff, 8'h09};
  logic [4:0]  lens[4] = '{5'h02, 5'h10, 5'h07, 5'h0b};
  always #5 pclk = ~pclk;
  serial_port uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_pin_i(sk_w), .serial_clock_pin_o(sk_o),
    .serial_clock_pin_oe(sk_oe), .controller_out_data_pin_i(co_w),
    .controller_out_data_pin_o(co_o), .controller_out_data_pin_oe(co_oe),
    .controller_in_data_pin_i(ci_w), .controller_in_data_pin_o(ci_o),
    .controller_in_data_pin_oe(ci_oe), .select_n_pin_i(sn_w), .select_n_pin_o(sn_o),
    .select_n_pin_oe(sn_oe));
  target_model far (.sclk(sk_w), .sel_n(sn_w), .cout(co_w), .cin(pcin), .pha(pha), .tx(ptx),
    .len(len), .rx(prx));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fails = 0;
    total_checks = 0;
    seed = 32'hc1b0a9af;
    ptx = 16'h0;
    len = 5'h02;
    pha = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(0, ra[i], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    apb(0, 8'h0c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped read");
    apb(1, 8'h40, 32'h1);
    chk({31'h0, er}, 32'h1, "unmapped write");
    $display("reset and map test done");
    apb(1, 8'h3c, 32'h888);
    repeat (4) @(posedge pclk);
    apb(0, 8'h3c, 32'h0);
    chk(rd, 32'h000c_0888, "gpio high");
    apb(1, 8'h3c, 32'h088);
    repeat (4) @(posedge pclk);
    apb(0, 8'h3c, 32'h0);
    chk(rd, 32'h0000_0088, "gpio low");
    apb(1, 8'h3c, 32'h0);
    $display("gpio test done");
    apb(1, 8'h00, 32'h3);
    // one word a group, so the far side can be reloaded between words
    // odd words run phase 1
    for (int k = 0; k < 4; k++) begin
      len = lens[k];
      pha = 1'(k);
      dtx = 16'($random(seed));
      ptx = 16'($random(seed));
      m = (32'h1 << len) - 32'h1;
      q.push_back(32'(ptx) & m);
      apb(1, 8'h08, 32'($random(seed)) & 32'h0707 | 32'h0004);
      apb(1, 8'h10 + 8'(4 * k), {14'h0, 1'b0, pha, pss[k], 3'h0, len});
      apb(1, 8'h28, 32'(k));
      apb(1, 8'h2c, 32'(dtx));
      apb(1, 8'h30, 32'(k));
      apb(1, 8'h04, {16'h0, 8'(k), 8'(k)});
      apb(1, 8'h00, 32'h7);
      t = 0;
      do begin
        apb(0, 8'h38, 32'h0);
        t++;
      end while (rd[0] !== 1'b1 && t < 3000);
      chk(rd, 32'h1, "entry status");
      apb(0, 8'h20, 32'h0);
      chk(rd & 32'h2, 32'h2, "buffer full");
      apb(0, 8'h24, 32'h0);
      chk(rd & m, q.pop_front(), "received word");
      apb(0, 8'h34, 32'h0);
      chk(rd & m, 32'(ptx) & m, "entry rx word");
      apb(0, 8'h20, 32'h0);
      chk(rd & 32'h2, 32'h0, "full cleared");
      chk(32'(prx) & m, 32'(dtx) & m, "far side word");
      $display("word test %0d done", k);
    end
    tally_and_finish;
  end
  initial begin
    #900000;
    fails++;
    tally_and_finish;
  end
endmodule

// ### test/serial_port_assertions.sv
`timescale 1ns/10ps
// ************************
// bus and pin checks
// ************************
module serial_port_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe,
  input wire logic        controller_out_data_pin_o,
  input wire logic        select_n_pin_o,
  input wire logic        select_n_pin_oe
);
  wire sk = serial_clock_pin_o;
  wire sn = select_n_pin_o;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY_SETUP: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RD_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata outside access");
  AST_UNMAP: assert property (pready && (paddr == 8'h0c || paddr > 8'h3c) |-> pslverr)
    else $error("unmapped not refused");
  AST_RST_PINS: assert property ($rose(presetn) |-> sn && !select_n_pin_oe
    && !serial_clock_pin_oe)
    else $error("pins not idle after reset");
  AST_SCLK_SEL: assert property ($rose(sk) && serial_clock_pin_oe |-> !sn)
    else $error("clock edge while deselected");
  AST_SEL_LEAD: assert property ($fell(sn) |-> $stable(sk))
    else $error("clock moved with select");
  AST_DOUT: assert property ($rose(sk) && serial_clock_pin_oe
    |-> $stable(controller_out_data_pin_o))
    else $error("data moved on sampling edge");
endmodule
bind serial_port serial_port_assertions u_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .prdata, .pready, .pslverr, .serial_clock_pin_o, .serial_clock_pin_oe,
  .controller_out_data_pin_o, .select_n_pin_o, .select_n_pin_oe);

// ### test/target_model.sv
`timescale 1ns/10ps
// ************************
// far side target, polarity 0, either phase
// ************************
module target_model (
  // serial side
  input wire logic        sclk,
  input wire logic        sel_n,
  input wire logic        cout,
  output logic            cin,
  // word setup
  input wire logic        pha,
  input wire logic [15:0] tx,
  input wire logic [4:0]  len,
  output logic [15:0]     rx
);
  int n;
  bit armed;
  initial cin = 1'b1;
  always @(negedge sel_n) begin
    armed = 1'b1;
    n = len;
    rx = 16'h0;
    cin = tx[len-1];
  end
  // phase 0 takes on the rise and moves on the fall, phase 1 the other way round
  always @(posedge sclk) begin
    if (!sel_n && !pha) begin
      rx = {rx[14:0], cout};
    end else if (!sel_n && n > 0) begin
      n = n - 1;
      cin = tx[n];
    end
  end
  always @(negedge sclk) begin
    if (!sel_n && pha) begin
      rx = {rx[14:0], cout};
    end else if (!sel_n && n > 1) begin
      n = n - 1;
      cin = tx[n-1];
    end
  end
  // released line flips, stale data never matches by luck; nothing to flip before a frame
  always @(posedge sel_n) begin
    if (armed) begin
      cin = ~cin;
    end
  end
endmodule
